/* File: logic/miq_defs.svh */
// Constants for the identification query responder
`ifndef MIQ_DEFS_SVH
`define MIQ_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Clock and line timing
`define MIQ_CLK_HZ          200000000
`define MIQ_BAUD_BPS        9600
`define MIQ_BIT_CYCLES      (`MIQ_CLK_HZ / `MIQ_BAUD_BPS)

////////////////////////////////////////////////////////////////////////////////
// Characters
`define MIQ_CH_STX          8'h02
`define MIQ_CH_ETX          8'h03
`define MIQ_CH_CR           8'h0D
`define MIQ_CH_ZERO         8'h30
`define MIQ_CH_ONE          8'h31
`define MIQ_CH_O            8'h4F
`define MIQ_CH_K            8'h4B
`define MIQ_CH_I            8'h49
`define MIQ_CH_N            8'h4E
`define MIQ_CH_F            8'h46
`define MIQ_CH_SEL_ID       8'h36
`define MIQ_CH_SEL_CPU      8'h37
`define MIQ_CPU_MAX_CH      8'h31

////////////////////////////////////////////////////////////////////////////////
// Frame layout
`define MIQ_HEAD_SEL_IDX    4'h8
`define MIQ_HEAD_CK_LAST    4'hA
`define MIQ_REPLY_HDR_LEN   6'h07
`define MIQ_ID_BODY_LEN     6'h20
`define MIQ_CPU_BODY_LEN    6'h01
`define MIQ_MODEL_PFX_LEN   6'h05
`define MIQ_SUFFIX_POS      6'h07
`define MIQ_HEX_POS         6'h0C

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define MIQ_OFS_CTRL        12'h000
`define MIQ_OFS_MODE        12'h004
`define MIQ_OFS_SUFFIX_LO   12'h008
`define MIQ_OFS_SUFFIX_HI   12'h00C
`define MIQ_OFS_VERSION     12'h010
`define MIQ_OFS_RD_REFRESH  12'h014
`define MIQ_OFS_WR_REFRESH  12'h018
`define MIQ_OFS_STATUS      12'h01C

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define MIQ_CTRL_CK_BIT     8
`define MIQ_CTRL_EN_BIT     9
`define MIQ_MODE_RANGE_LSB  4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MIQ_RST_STATION     8'h01
`define MIQ_RST_WIRING      3'h1
`define MIQ_RST_RANGE       3'h1
`define MIQ_RST_SUFFIX      40'h3030303030
`define MIQ_RST_VERSION     16'h0100
`define MIQ_RST_RD_START    16'h0001
`define MIQ_RST_RD_COUNT    16'h0022
`define MIQ_RST_WR_START    16'h0001
`define MIQ_RST_WR_COUNT    16'h0000

`endif

/* File: logic/miq_pkg.sv */
// Types for the identification query responder
package miq_pkg;

  typedef enum logic [2:0] {
    ST_WAIT_STX,
    ST_HEAD,
    ST_ETX,
    ST_CR,
    ST_REPLY,
    ST_DRAIN
  } miq_state_type;

endpackage

/* File: logic/miq_uart.sv */
// Serial receiver and transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
module miq_uart #(
  parameter int BIT_CYCLES = 20833
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rxd,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  output logic            tx_busy,
  output logic            txd
);

  localparam int CW = $clog2(BIT_CYCLES + 1);

  logic [CW-1:0] rx_cnt_q;
  logic [3:0]    rx_bit_q;
  logic          rx_on_q;
  logic [7:0]    rx_shift_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0]    tx_bit_q;
  logic [9:0]    tx_shift_q;

  //////////////////////////////////////////////////////////////////////////////
  // Receiver, samples mid bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_q   <= '0;
      rx_bit_q   <= 4'h0;
      rx_on_q    <= 1'b0;
      rx_shift_q <= 8'h00;
      rx_valid   <= 1'b0;
      rx_data    <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_on_q) begin
        if (!rxd) begin
          rx_on_q  <= 1'b1;
          rx_cnt_q <= CW'(BIT_CYCLES / 2);
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= CW'(BIT_CYCLES - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          rx_on_q <= !rxd;
        end else if (rx_bit_q == 4'h9) begin
          rx_on_q  <= 1'b0;
          rx_valid <= rxd;
          rx_data  <= rx_shift_q;
        end else begin
          rx_shift_q <= {rxd, rx_shift_q[7:1]};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_q   <= '0;
      tx_bit_q   <= 4'h0;
      tx_shift_q <= 10'h3FF;
      tx_busy    <= 1'b0;
      txd        <= 1'b1;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy    <= 1'b1;
        tx_shift_q <= {1'b1, tx_data, 1'b0};
        tx_bit_q   <= 4'h0;
        tx_cnt_q   <= '0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else if (tx_bit_q == 4'hA) begin
      tx_busy <= 1'b0;
    end else begin
      txd        <= tx_shift_q[0];
      tx_shift_q <= {1'b1, tx_shift_q[9:1]};
      tx_bit_q   <= tx_bit_q + 4'h1;
      tx_cnt_q   <= CW'(BIT_CYCLES - 1);
    end
  end

endmodule // miq_uart

/* File: logic/miq_responder.sv */
// Identification and processor-count query responder with APB registers
//
// What this block does
// - Identification reply echoes station, OK, model, version
// - First code digit gives selected wiring
// - Second code digit gives selected input range
// - Rest of model string is stored suffix
// - Version field: version digits then revision
// - Processor-count reply is always character one
// - Both ends share 9600 8N1 line settings
// - Checksum element absent when option off
`timescale 1ns/1ps
`include "miq_defs.svh"
module miq_responder #(
  parameter int          BIT_CYCLES = `MIQ_BIT_CYCLES,
  // Model prefix, arbitrary
  parameter logic [39:0] MODEL_NAME = 40'h4D51583930
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_en
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] digit_char(input logic [3:0] n);
    digit_char = {4'h3, n};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  station_q;
  logic        ck_en_q;
  logic        resp_en_q;
  logic [2:0]  wiring_q;
  logic [2:0]  range_q;
  logic [39:0] suffix_q;
  logic [15:0] version_q;
  logic [15:0] rd_start_q;
  logic [15:0] rd_count_q;
  logic [15:0] wr_start_q;
  logic [15:0] wr_count_q;
  logic [7:0]  answered_q;
  logic [7:0]  rejected_q;

  miq_pkg::miq_state_type state_q;
  logic [3:0]  idx_q;
  logic [7:0]  rx_sum_q;
  logic        good_q;
  logic        is_cpu_q;
  logic [5:0]  k_q;
  logic [7:0]  tx_sum_q;
  logic        tx_start_q;
  logic [7:0]  tx_data_q;

  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_busy;

  logic        apb_access;
  logic        wr_fire;
  logic        addr_hit;
  logic [31:0] rd_mux;

  logic [3:0]  head_last;
  logic        head_match;
  logic        tx_ready;
  logic        frame_done;
  logic        frame_accept;

  logic [5:0]  body_end;
  logic [5:0]  j;
  logic [5:0]  off;
  logic [4:0]  ni;
  logic [79:0] hex_word;
  logic [79:0] hex_shift;
  logic [39:0] pfx_shift;
  logic [39:0] sfx_shift;
  logic [7:0]  rep_byte;
  logic        rep_summed;
  logic        rep_last;

  //////////////////////////////////////////////////////////////////////////////
  // Serial line
  miq_uart #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_uart (
    .pclk     (pclk),
    .presetn  (presetn),
    .rxd      (rxd),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_start (tx_start_q),
    .tx_data  (tx_data_q),
    .tx_busy  (tx_busy),
    .txd      (txd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  assign apb_access = psel & penable;
  assign wr_fire    = apb_access & pready & pwrite & ~pslverr;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `MIQ_OFS_CTRL:       rd_mux = {22'h0, resp_en_q, ck_en_q, station_q};
      `MIQ_OFS_MODE:       rd_mux = {25'h0, range_q, 1'b0, wiring_q};
      `MIQ_OFS_SUFFIX_LO:  rd_mux = suffix_q[39:8];
      `MIQ_OFS_SUFFIX_HI:  rd_mux = {24'h0, suffix_q[7:0]};
      `MIQ_OFS_VERSION:    rd_mux = {16'h0, version_q};
      `MIQ_OFS_RD_REFRESH: rd_mux = {rd_count_q, rd_start_q};
      `MIQ_OFS_WR_REFRESH: rd_mux = {wr_count_q, wr_start_q};
      `MIQ_OFS_STATUS:     rd_mux = {8'h0, rejected_q, answered_q, 5'h0, 3'(state_q)};
      default:             addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= apb_access & ~pready;
      if (apb_access & ~pready) begin
        pslverr <= ~addr_hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_q  <= `MIQ_RST_STATION;
      ck_en_q    <= 1'b0;
      resp_en_q  <= 1'b1;
      wiring_q   <= `MIQ_RST_WIRING;
      range_q    <= `MIQ_RST_RANGE;
      suffix_q   <= `MIQ_RST_SUFFIX;
      version_q  <= `MIQ_RST_VERSION;
      rd_start_q <= `MIQ_RST_RD_START;
      rd_count_q <= `MIQ_RST_RD_COUNT;
      wr_start_q <= `MIQ_RST_WR_START;
      wr_count_q <= `MIQ_RST_WR_COUNT;
    end else if (wr_fire) begin
      case (paddr)
        `MIQ_OFS_CTRL: begin
          station_q <= pwdata[7:0];
          ck_en_q   <= pwdata[`MIQ_CTRL_CK_BIT];
          resp_en_q <= pwdata[`MIQ_CTRL_EN_BIT];
        end
        `MIQ_OFS_MODE: begin
          wiring_q <= pwdata[2:0];
          range_q  <= pwdata[`MIQ_MODE_RANGE_LSB +: 3];
        end
        `MIQ_OFS_SUFFIX_LO:  suffix_q[39:8] <= pwdata;
        `MIQ_OFS_SUFFIX_HI:  suffix_q[7:0]  <= pwdata[7:0];
        `MIQ_OFS_VERSION:    version_q      <= pwdata[15:0];
        `MIQ_OFS_RD_REFRESH: begin
          rd_start_q <= pwdata[15:0];
          rd_count_q <= pwdata[31:16];
        end
        `MIQ_OFS_WR_REFRESH: begin
          wr_start_q <= pwdata[15:0];
          wr_count_q <= pwdata[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command header check
  assign head_last = ck_en_q ? `MIQ_HEAD_CK_LAST : `MIQ_HEAD_SEL_IDX;

  always_comb begin
    case (idx_q)
      4'h0:    head_match = rx_data == digit_char(station_q[7:4]);
      4'h1:    head_match = rx_data == digit_char(station_q[3:0]);
      4'h2:    head_match = rx_data == `MIQ_CH_ZERO;
      4'h3:    head_match = rx_data == `MIQ_CH_ONE;
      4'h4:    head_match = rx_data == `MIQ_CH_ZERO;
      4'h5:    head_match = rx_data == `MIQ_CH_I;
      4'h6:    head_match = rx_data == `MIQ_CH_N;
      4'h7:    head_match = rx_data == `MIQ_CH_F;
      4'h8:    head_match = (rx_data == `MIQ_CH_SEL_ID) || (rx_data == `MIQ_CH_SEL_CPU);
      4'h9:    head_match = rx_data == hex_char(rx_sum_q[7:4]);
      4'hA:    head_match = rx_data == hex_char(rx_sum_q[3:0]);
      default: head_match = 1'b0;
    endcase
  end

  assign tx_ready     = ~tx_busy & ~tx_start_q;
  assign frame_done   = rx_valid && (state_q == miq_pkg::ST_CR) && rx_data != `MIQ_CH_STX;
  assign frame_accept = frame_done && rx_data == `MIQ_CH_CR && good_q && resp_en_q;

  //////////////////////////////////////////////////////////////////////////////
  // Frame state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= miq_pkg::ST_WAIT_STX;
      idx_q    <= 4'h0;
      rx_sum_q <= 8'h00;
      good_q   <= 1'b0;
      is_cpu_q <= 1'b0;
    end else begin
      case (state_q)
        miq_pkg::ST_REPLY: begin
          if (tx_ready && rep_last) state_q <= miq_pkg::ST_DRAIN;
        end
        miq_pkg::ST_DRAIN: begin
          if (tx_ready) state_q <= miq_pkg::ST_WAIT_STX;
        end
        default: begin
          if (rx_valid && rx_data == `MIQ_CH_STX) begin
            state_q  <= miq_pkg::ST_HEAD;
            idx_q    <= 4'h0;
            rx_sum_q <= 8'h00;
            good_q   <= 1'b1;
          end else if (rx_valid) begin
            case (state_q)
              miq_pkg::ST_HEAD: begin
                good_q <= good_q & head_match;
                if (idx_q <= `MIQ_HEAD_SEL_IDX) rx_sum_q <= rx_sum_q + rx_data;
                if (idx_q == `MIQ_HEAD_SEL_IDX) is_cpu_q <= rx_data == `MIQ_CH_SEL_CPU;
                if (idx_q == head_last) state_q <= miq_pkg::ST_ETX;
                else idx_q <= idx_q + 4'h1;
              end
              miq_pkg::ST_ETX: begin
                good_q  <= good_q & (rx_data == `MIQ_CH_ETX);
                state_q <= miq_pkg::ST_CR;
              end
              miq_pkg::ST_CR: begin
                state_q <= frame_accept ? miq_pkg::ST_REPLY : miq_pkg::ST_WAIT_STX;
              end
              default: state_q <= miq_pkg::ST_WAIT_STX;
            endcase
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      answered_q <= 8'h00;
      rejected_q <= 8'h00;
    end else if (frame_done) begin
      if (frame_accept) answered_q <= answered_q + 8'h01;
      else rejected_q <= rejected_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply character selection
  assign body_end  = `MIQ_REPLY_HDR_LEN + (is_cpu_q ? `MIQ_CPU_BODY_LEN : `MIQ_ID_BODY_LEN);
  assign j         = k_q - `MIQ_REPLY_HDR_LEN;
  assign off       = k_q - body_end;
  assign ni        = 5'(j - `MIQ_HEX_POS);
  assign hex_word  = {version_q, rd_start_q, rd_count_q, wr_start_q, wr_count_q};
  assign hex_shift = hex_word >> (7'h4C - {ni, 2'b00});
  assign pfx_shift = MODEL_NAME >> (6'h20 - {j[2:0], 3'b000});
  assign sfx_shift = suffix_q >> (6'h20 - {3'(j - `MIQ_SUFFIX_POS), 3'b000});

  always_comb begin
    rep_byte   = `MIQ_CH_CR;
    rep_summed = 1'b0;
    rep_last   = 1'b0;
    if (k_q < `MIQ_REPLY_HDR_LEN) begin
      rep_summed = k_q != 6'h00;
      case (k_q)
        6'h00:   rep_byte = `MIQ_CH_STX;
        6'h01:   rep_byte = digit_char(station_q[7:4]);
        6'h02:   rep_byte = digit_char(station_q[3:0]);
        6'h03:   rep_byte = `MIQ_CH_ZERO;
        6'h04:   rep_byte = `MIQ_CH_ONE;
        6'h05:   rep_byte = `MIQ_CH_O;
        default: rep_byte = `MIQ_CH_K;
      endcase
    end else if (k_q < body_end) begin
      rep_summed = 1'b1;
      if (is_cpu_q) rep_byte = `MIQ_CPU_MAX_CH;
      else if (j < `MIQ_MODEL_PFX_LEN) rep_byte = pfx_shift[7:0];
      else if (j == `MIQ_MODEL_PFX_LEN) rep_byte = digit_char({1'b0, wiring_q});
      else if (j == `MIQ_SUFFIX_POS - 6'h01) rep_byte = digit_char({1'b0, range_q});
      else if (j < `MIQ_HEX_POS) rep_byte = sfx_shift[7:0];
      else rep_byte = hex_char(hex_shift[3:0]);
    end else if (ck_en_q) begin
      case (off)
        6'h00:   rep_byte = hex_char(tx_sum_q[7:4]);
        6'h01:   rep_byte = hex_char(tx_sum_q[3:0]);
        6'h02:   rep_byte = `MIQ_CH_ETX;
        default: rep_last = 1'b1;
      endcase
    end else begin
      if (off == 6'h00) rep_byte = `MIQ_CH_ETX;
      else rep_last = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply sender
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_q        <= 6'h00;
      tx_sum_q   <= 8'h00;
      tx_start_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else begin
      tx_start_q <= 1'b0;
      if (state_q != miq_pkg::ST_REPLY) begin
        k_q      <= 6'h00;
        tx_sum_q <= 8'h00;
      end else if (tx_ready) begin
        tx_start_q <= 1'b1;
        tx_data_q  <= rep_byte;
        k_q        <= k_q + 6'h01;
        if (rep_summed) tx_sum_q <= tx_sum_q + rep_byte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line driver enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_en <= 1'b0;
    else tx_en <= (state_q == miq_pkg::ST_REPLY) || (state_q == miq_pkg::ST_DRAIN);
  end

endmodule // miq_responder

/* File: bench/miq_props.sv */
// Port checker for the query responder
`timescale 1ns/1ps
module miq_props #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        txd,
  input wire logic        tx_en
);
  logic [15:0] lo_cnt_q;
  logic [15:0] hi_cnt_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // Run lengths of the line level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt_q <= 16'h0000;
    else if (!txd) lo_cnt_q <= lo_cnt_q + 16'h0001;
    else lo_cnt_q <= 16'h0000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt_q <= 16'h0000;
    else if (!txd) hi_cnt_q <= 16'h0000;
    else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
  end

  ////////////////////////////////////////
  property p_line_idle;
    !tx_en |-> txd;
  endproperty
  a_line_idle: assert property (p_line_idle)
    else $error("txd low while driver off");
  property p_drv_rise;
    $rose(tx_en) |-> txd ##[1:4] !txd;
  endproperty
  a_drv_rise: assert property (p_drv_rise)
    else $error("no start bit after driver on");
  property p_bit_time;
    $rose(txd) |-> (lo_cnt_q % BIT_CYCLES) == 0;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("low run not whole bits");
  property p_drv_hold;
    $fell(tx_en) |-> hi_cnt_q >= BIT_CYCLES && hi_cnt_q <= BIT_CYCLES + 4;
  endproperty
  a_drv_hold: assert property (p_drv_hold)
    else $error("driver off before stop bit end");
  property p_ready_wait;
    (psel && penable && !$past(penable)) |-> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("ready not one wait state");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_gate;
    pslverr |-> pready;
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error without ready");
  property p_unmapped;
    (pready && paddr > 12'h01C) |-> pslverr && (pwrite || prdata == 32'h00000000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
endmodule // miq_props

bind miq_responder miq_props #(.BIT_CYCLES(BIT_CYCLES)) miq_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
  .tx_en(tx_en));

/* File: bench/miq_host.sv */
// Host controller model on the serial line
`timescale 1ns/1ps
module miq_host #(
  parameter int BIT = 16
) (
  input  wire logic pclk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_en
);
  logic [7:0] rx_q[$];
  logic [7:0] rb;

  initial rxd = 1'b1;

  ////////////////////////////////////////
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // One 8N1 character, LSB first
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask

  task automatic query(input logic [15:0] st, input logic [7:0] sel, input logic ck);
    logic [7:0] q[$];
    logic [7:0] s;
    q = {st[15:8], st[7:0], 8'h30, 8'h31, 8'h30, 8'h49, 8'h4E, 8'h46, sel};
    s = 8'h00;
    foreach (q[i]) s += q[i];
    if (ck) q = {q, hx(s[7:4]), hx(s[3:0])};
    q = {8'h02, q, 8'h03, 8'h0D};
    foreach (q[i]) put(q[i]);
  endtask

  ////////////////////////////////////////
  // Reply collector, mid-bit sampling
  always begin
    @(posedge pclk iff (tx_en && !txd));
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge pclk);
      rb[i] = txd;
    end
    repeat (BIT) @(posedge pclk);
    if (txd) rx_q.push_back(rb);
  end
endmodule // miq_host

/* File: bench/test_meter_info_query_responder.sv */
// Self-checking bench for the query responder
`timescale 1ns/1ps
module test_meter_info_query_responder;
  localparam int          BITC  = 16;
  localparam logic [39:0] MODEL = 40'h4142434445;
  localparam logic [39:0] SFX   = 40'h3641374239;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        tx_en;
  logic [7:0]  exp_q[$];
  logic [7:0]  sum;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          n_checks;
  int          cyc = 0;

  miq_responder #(.BIT_CYCLES(BITC), .MODEL_NAME(MODEL)) miq_responder_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_en(tx_en));
  miq_host #(.BIT(BITC)) miq_host_i (.pclk(pclk), .rxd(rxd), .txd(txd), .tx_en(tx_en));

  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk1("pslverr", a > 12'h01C, pslverr);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////
  task automatic add(input logic [7:0] b);
    exp_q.push_back(b);
    sum += b;
  endtask

  task automatic add16(input logic [15:0] v);
    for (int i = 3; i >= 0; i--) add(miq_host_i.hx(v[4*i+:4]));
  endtask

  task automatic head(input logic [15:0] st);
    exp_q = {8'h02};
    sum = 8'h00;
    add(st[15:8]);
    add(st[7:0]);
    add(8'h30);
    add(8'h31);
    add(8'h4F);
    add(8'h4B);
  endtask

  task automatic tail(input logic ck);
    if (ck) exp_q = {exp_q, miq_host_i.hx(sum[7:4]), miq_host_i.hx(sum[3:0])};
    exp_q = {exp_q, 8'h03, 8'h0D};
  endtask

  task automatic exp_id(input int w, input int r, input logic ck);
    head(16'h3031);
    for (int i = 4; i >= 0; i--) add(MODEL[8*i+:8]);
    add(8'(8'h30 + w));
    add(8'(8'h30 + r));
    for (int i = 4; i >= 0; i--) add(SFX[8*i+:8]);
    add16(16'h0305);
    add16(16'h0001);
    add16(16'h0022);
    add16(16'h0010);
    add16(16'h000A);
    tail(ck);
  endtask

  task automatic ask(input logic [15:0] st, input logic [7:0] sel, input logic ck);
    miq_host_i.rx_q.delete();
    @(posedge pclk);
    miq_host_i.query(st, sel, ck);
  endtask

  task automatic reply_chk;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12000; i++) begin
      @(posedge pclk);
      if (tx_en === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    chk1("reply seen", 1'b1, seen);
    chk32("reply length", exp_q.size(), miq_host_i.rx_q.size());
    foreach (exp_q[i]) chk8("reply byte", exp_q[i], miq_host_i.rx_q[i]);
  endtask

  ////////////////////////////////////////
  // Register reset values and a refused address
  task automatic t_reset;
    logic [31:0] tbl[8];
    tbl = '{32'h00000201, 32'h00000011, 32'h30303030, 32'h00000030,
            32'h00000100, 32'h00220001, 32'h00000001, 32'h00000000};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h00000000);
      chk32("reset value", tbl[i], rd);
    end
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk1("write error", 1'b1, err);
    apb(1'b0, 12'h020, 32'h00000000);
    chk1("read error", 1'b1, err);
  endtask

  // Stored suffix, version and refresh area
  task automatic t_setup;
    logic [11:0] a[4];
    logic [31:0] v[4];
    a = '{12'h008, 12'h00C, 12'h010, 12'h018};
    v = '{SFX[39:8], {24'h000000, SFX[7:0]}, 32'h00000305, 32'h000A0010};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, a[i], v[i]);
      apb(1'b0, a[i], 32'h00000000);
      chk32("readback", v[i], rd);
    end
  endtask

  task automatic t_id_ck;
    apb(1'b1, 12'h000, 32'h00000301);
    exp_id(1, 1, 1'b1);
    ask(16'h3031, 8'h36, 1'b1);
    reply_chk();
  endtask

  task automatic t_id_modes;
    apb(1'b1, 12'h000, 32'h00000201);
    for (int w = 1; w <= 5; w++) begin
      apb(1'b1, 12'h004, {25'h0000000, 3'(w + 1), 1'b0, 3'(w)});
      exp_id(w, w + 1, 1'b0);
      ask(16'h3031, 8'h36, 1'b0);
      reply_chk();
    end
  endtask

  task automatic no_reply(input logic [15:0] st);
    logic seen;
    seen = 1'b0;
    ask(st, 8'h37, 1'b0);
    repeat (400) begin
      @(posedge pclk);
      if (tx_en !== 1'b0) seen = 1'b1;
    end
    chk1("unwanted reply", 1'b0, seen);
  endtask

  task automatic t_station;
    no_reply(16'h3032);
    apb(1'b1, 12'h000, 32'h00000001);
    no_reply(16'h3031);
    apb(1'b0, 12'h01C, 32'h00000000);
    chk32("frame counts", 32'h00020600, rd);
    apb(1'b1, 12'h000, 32'h00000227);
    head(16'h3237);
    add(8'h31);
    tail(1'b0);
    ask(16'h3237, 8'h37, 1'b0);
    reply_chk();
  endtask

  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_setup();
    t_id_ck();
    t_id_modes();
    t_station();
    tally_and_finish();
  end
endmodule // test_meter_info_query_responder
